// ==== flr_pkg.sv ====
package flr_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int          ADDR_W        = 12;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************
  // Register indices (byte address is four times)
  // ****************************************
  localparam logic [7:0]  IDX_CONTROL   = 8'h80;
  localparam logic [7:0]  IDX_DIVIDER   = 8'h81;
  localparam logic [7:0]  IDX_FRACTION  = 8'h82;
  localparam logic [7:0]  IDX_INTEGER   = 8'h83;
  localparam logic [7:0]  IDX_STATUS    = 8'h84;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          ENA_BIT       = 0;
  localparam int          FRAC_BIT      = 2;
  localparam int          SRC_LSB       = 11;
  localparam int          RATE_LSB      = 6;
  localparam int          OUTDIV_LSB    = 3;
  localparam int          RATIO_LSB     = 0;
  localparam int          INT_W         = 10;
  localparam int          FRAC_W        = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_CONTROL   = 16'h0000;
  localparam logic [15:0] RST_DIVIDER   = 16'h0000;
  localparam logic [15:0] RST_FRACTION  = 16'h0000;
  localparam logic [15:0] RST_INTEGER   = 16'h0000;

  typedef enum logic [1:0] {
    REF_MASTER   = 2'h0,
    REF_BIT      = 2'h1,
    REF_FRAME    = 2'h2,
    REF_RESERVED = 2'h3
  } flr_refsrc_type;

  // Ratio code to shift: 0,1,2,3 then 4 for any top-bit code
  function automatic logic [2:0] flr_ratio_shift(input logic [2:0] code);
    return code[2] ? 3'h4 : {1'b0, code[1:0]};
  endfunction : flr_ratio_shift

  // Output divider code to divisor 2..256
  function automatic logic [8:0] flr_outdiv(input logic [2:0] code);
    return 9'h002 << code;
  endfunction : flr_outdiv

endpackage : flr_pkg

// ==== flr_rate_divider.sv ====
module flr_rate_divider
  import flr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Control
  input  wire logic       enable,
  input  wire logic [8:0] divisor,
  // Enable pulse
  output logic            pulse
);

  typedef struct packed {
    logic [8:0] count;
    logic       pulse;
  } flr_div_state_type;

  flr_div_state_type s;
  flr_div_state_type next_s;

  always_comb begin
    next_s       = s;
    next_s.pulse = 1'b0;
    if (!enable) begin
      next_s.count = 9'h000;
    end else if (s.count >= divisor - 9'h001) begin
      next_s.count = 9'h000;
      next_s.pulse = 1'b1;
    end else begin
      next_s.count = s.count + 9'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

  // ****************************************
  // Checks
  // ****************************************
  AST_DIV_GAP: assert property (@(posedge clock) disable iff (!rst_n)
    (pulse && divisor >= 9'h002 && $stable(divisor)) |=> !pulse)
    else $error("Divider pulses on adjacent cycles");

endmodule : flr_rate_divider

// ==== flr_ratio_config.sv ====
// What this block does
// - Rate codes 101..111 divide oscillator by 6..8.
// - Output divider codes give divisors 2 to 256.
// - Ratio codes give 1,2,4,8; top bit gives 16.
// - Fraction multiplier is unsigned, top bit one half.
// - Integer multiplier is unsigned, least bit one.
// - Mode bit: 0 integer, 1 fractional operation.
// - Source 00 master, 01 bit, 10 frame; 11 reserved.
//
// Chosen here: the AXI4-Lite interface to the registers.
module flr_ratio_config
  import flr_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Loop configuration
  output logic                   loopEnable,
  output logic                   fractionModeSelect,
  output logic [1:0]             referenceSourceSelect,
  output logic                   referenceSourceReserved,
  output logic [4:0]             ratioDivisor,
  output logic [25:0]            loopMultiplier,
  output logic [29:0]            oscillatorTarget,
  // Enable pulses
  output logic                   loopOutputClock,
  output logic                   controlRateEnable
);

  typedef struct packed {
    logic              awReady;
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wReady;
    logic              wHeld;
    logic [15:0]       wData;
    logic [1:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [15:0]       rData;
    logic [1:0]        rResp;
    logic [15:0]       control;
    logic [15:0]       divider;
    logic [15:0]       fraction;
    logic [15:0]       integ;
    logic [1:0]        refSel;
    logic              refReserved;
    logic [4:0]        ratioDiv;
    logic [2:0]        ratioShift;
    logic [25:0]       multiplier;
    logic [29:0]       target;
  } flr_state_type;

  flr_state_type s;
  flr_state_type next_s;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a[ADDR_W-1:2] == {2'h0, idx};
  endfunction : hit

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] st);
    return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  always_comb begin
    next_s = s;
    // ****************************************
    // Write channel
    // ****************************************
    if (awvalid && s.awReady) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata[15:0];
      next_s.wStrb = wstrb[1:0];
    end
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end
    // Address and data may arrive in either order
    if (next_s.awHeld && next_s.wHeld && !next_s.bValid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = RESP_OKAY;
      if (hit(next_s.awAddr, IDX_CONTROL)) begin
        next_s.control = merge(s.control, next_s.wData, next_s.wStrb);
      end else if (hit(next_s.awAddr, IDX_DIVIDER)) begin
        next_s.divider = merge(s.divider, next_s.wData, next_s.wStrb);
      end else if (hit(next_s.awAddr, IDX_FRACTION)) begin
        next_s.fraction = merge(s.fraction, next_s.wData, next_s.wStrb);
      end else if (hit(next_s.awAddr, IDX_INTEGER)) begin
        next_s.integ = merge(s.integ, next_s.wData, next_s.wStrb);
      end else if (!hit(next_s.awAddr, IDX_STATUS)) begin
        next_s.bResp = RESP_SLVERR;
      end
    end
    next_s.awReady = !next_s.awHeld && !next_s.bValid;
    next_s.wReady  = !next_s.wHeld && !next_s.bValid;
    // ****************************************
    // Read channel
    // ****************************************
    if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
    end
    if (arvalid && s.arReady) begin
      next_s.rValid = 1'b1;
      next_s.rResp  = RESP_OKAY;
      next_s.rData  = 16'h0000;
      if (hit(araddr, IDX_CONTROL)) begin
        next_s.rData = s.control;
      end else if (hit(araddr, IDX_DIVIDER)) begin
        next_s.rData = s.divider;
      end else if (hit(araddr, IDX_FRACTION)) begin
        next_s.rData = s.fraction;
      end else if (hit(araddr, IDX_INTEGER)) begin
        next_s.rData = s.integ;
      end else if (hit(araddr, IDX_STATUS)) begin
        next_s.rData = {8'h00, s.refReserved, s.refSel, s.ratioDiv};
      end else begin
        next_s.rResp = RESP_SLVERR;
      end
    end
    next_s.arReady = !next_s.rValid;
    // ****************************************
    // Loop settings
    // ****************************************
    // Reserved source code keeps the last legal selection
    if (s.divider[SRC_LSB+:2] != REF_RESERVED) begin
      next_s.refSel = s.divider[SRC_LSB+:2];
    end
    next_s.refReserved = s.divider[SRC_LSB+:2] == REF_RESERVED;
    next_s.ratioShift  = flr_ratio_shift(s.divider[RATIO_LSB+:3]);
    next_s.ratioDiv    = 5'h01 << flr_ratio_shift(s.divider[RATIO_LSB+:3]);
    // Integer part over a 16-bit binary fraction; integer mode drops it
    next_s.multiplier  = {s.integ[INT_W-1:0],
                          s.control[FRAC_BIT] ? s.fraction : 16'h0000};
    next_s.target      = {4'h0, s.multiplier} << s.ratioShift;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.control  <= RST_CONTROL;
      s.divider  <= RST_DIVIDER;
      s.fraction <= RST_FRACTION;
      s.integ    <= RST_INTEGER;
      s.ratioDiv <= 5'h01;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Rate dividers
  // ****************************************
  logic [8:0] outDivisor;
  logic [8:0] rateDivisor;

  assign outDivisor  = flr_outdiv(s.divider[OUTDIV_LSB+:3]);
  assign rateDivisor = {6'h00, s.divider[RATE_LSB+:3]} + 9'h001;

  flr_rate_divider outDiv (
    .clock   (clock),
    .rst_n   (rst_n),
    .enable  (s.control[ENA_BIT]),
    .divisor (outDivisor),
    .pulse   (loopOutputClock)
  );

  flr_rate_divider rateDiv (
    .clock   (clock),
    .rst_n   (rst_n),
    .enable  (s.control[ENA_BIT]),
    .divisor (rateDivisor),
    .pulse   (controlRateEnable)
  );

  assign awready                 = s.awReady;
  assign wready                  = s.wReady;
  assign bvalid                  = s.bValid;
  assign bresp                   = s.bResp;
  assign arready                 = s.arReady;
  assign rvalid                  = s.rValid;
  assign rdata                   = {16'h0000, s.rData};
  assign rresp                   = s.rResp;
  assign loopEnable              = s.control[ENA_BIT];
  assign fractionModeSelect      = s.control[FRAC_BIT];
  assign referenceSourceSelect   = s.refSel;
  assign referenceSourceReserved = s.refReserved;
  assign ratioDivisor            = s.ratioDiv;
  assign loopMultiplier          = s.multiplier;
  assign oscillatorTarget        = s.target;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Address and data accepted together on one edge
  sequence WRITE_TAKEN;
    awvalid && awready && wvalid && wready;
  endsequence

  AST_RATIO_TOP: assert property (s.divider[2] |=> ratioDivisor == 5'h10)
    else $error("Top ratio bit must give sixteen");
  AST_RATIO_LOW: assert property (!s.divider[2] |=>
    ratioDivisor == (5'h01 << $past(s.divider[1:0])))
    else $error("Ratio divisor wrong");
  AST_INT_MODE: assert property (!s.control[FRAC_BIT] |=> loopMultiplier[15:0] == 16'h0000)
    else $error("Integer mode kept a fraction");
  AST_FRAC_MODE: assert property (s.control[FRAC_BIT] |=> loopMultiplier[15:0] ==
    $past(s.fraction))
    else $error("Fraction not passed through");
  AST_INT_PART: assert property (##1 loopMultiplier[25:16] == $past(s.integ[9:0]))
    else $error("Integer part wrong");
  AST_REF_HOLD: assert property (s.divider[12:11] == 2'h3 |=>
    referenceSourceReserved && $stable(referenceSourceSelect))
    else $error("Reserved source changed selection");
  AST_TARGET: assert property (##1 oscillatorTarget ==
    ({4'h0, $past(loopMultiplier)} << $past(s.ratioShift)))
    else $error("Oscillator target wrong");
  AST_RATE_DIV: assert property (s.divider[8:6] == 3'h7 |-> rateDivisor == 9'h008)
    else $error("Rate code 111 must divide by eight");
  AST_BRESP: assert property (WRITE_TAKEN |=> bvalid && !awready && !wready)
    else $error("Write not answered or ready raised while response pending");

endmodule : flr_ratio_config

// ==== test_flr_ratio_config.sv ====
module test_flr_ratio_config
  import flr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench signals
  // ****
  logic              clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, loopEnable, fractionModeSelect;
  logic              referenceSourceReserved, loopOutputClock, controlRateEnable;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, referenceSourceSelect, rsp;
  logic [4:0]        ratioDivisor;
  logic [25:0]       loopMultiplier;
  logic [29:0]       oscillatorTarget;
  int                mismatches, num_checks, per;

  flr_ratio_config dut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .loopEnable(loopEnable), .fractionModeSelect(fractionModeSelect),
    .referenceSourceSelect(referenceSourceSelect),
    .referenceSourceReserved(referenceSourceReserved), .ratioDivisor(ratioDivisor),
    .loopMultiplier(loopMultiplier), .oscillatorTarget(oscillatorTarget),
    .loopOutputClock(loopOutputClock), .controlRateEnable(controlRateEnable));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ****
  // Bus and compare tasks
  // ****
  function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : addr_of

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    awaddr  <= addr_of(idx);
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 50) begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 50) check(32'h1, 32'h0, "write hang");
  endtask : bus_write

  task automatic bus_read(input logic [7:0] idx);
    int n;
    n = 0;
    @(posedge clock);
    araddr  <= addr_of(idx);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 50) begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 50) check(32'h1, 32'h0, "read hang");
  endtask : bus_read

  // Skips the first pulse so a divisor change mid-count cannot skew the figure
  task automatic measure(input bit sel);
    int n, k, first;
    n = 0;
    k = 0;
    first = 0;
    per = 0;
    while (n < 1200 && per == 0) begin
      @(posedge clock);
      n++;
      if ((sel ? controlRateEnable : loopOutputClock) === 1'b1) begin
        k++;
        if (k == 2) first = n;
        if (k == 3) per = n - first;
      end
    end
  endtask : measure

  // ****
  // Scenarios
  // ****
  task automatic test_reset;
    check(32'(ratioDivisor), 32'h1, "reset ratio");
    check(32'({loopEnable, fractionModeSelect}), 32'h0, "reset enables");
    bus_read(IDX_CONTROL);
    check(rd, 32'h0, "reset control");
    bus_read(IDX_DIVIDER);
    check(rd, 32'h0, "reset divider");
    bus_read(IDX_FRACTION);
    check(rd, 32'h0, "reset fraction");
    bus_read(IDX_INTEGER);
    check(rd, 32'h0, "reset integer");
    $display("test reset done");
  endtask : test_reset

  task automatic test_ratio;
    logic [4:0] exp;
    for (int c = 0; c < 8; c++) begin
      bus_write(IDX_DIVIDER, 16'(c));
      repeat (3) @(posedge clock);
      exp = c[2] ? 5'h10 : 5'(1 << c[1:0]);
      check(32'(ratioDivisor), 32'(exp), "ratio");
      bus_read(IDX_STATUS);
      check(32'(rd[4:0]), 32'(exp), "status ratio");
    end
    $display("test ratio done");
  endtask : test_ratio

  task automatic test_mult;
    bus_write(IDX_CONTROL, 16'h0004);
    bus_write(IDX_FRACTION, 16'h8000);
    bus_write(IDX_INTEGER, 16'h03ff);
    bus_write(IDX_DIVIDER, 16'h0003);
    repeat (4) @(posedge clock);
    check(32'(fractionModeSelect), 32'h1, "fraction select");
    check(32'(loopMultiplier), 32'h03ff8000, "fraction mult");
    check(32'(oscillatorTarget), 32'h1ffc0000, "target");
    bus_read(IDX_FRACTION);
    check(rd, 32'h8000, "fraction back");
    // High byte lane only: low byte must keep its old value
    wstrb <= 4'h2;
    bus_write(IDX_FRACTION, 16'h1234);
    wstrb <= 4'h3;
    bus_read(IDX_FRACTION);
    check(rd, 32'h1200, "fraction byte lane");
    bus_write(IDX_CONTROL, 16'h0000);
    repeat (4) @(posedge clock);
    check(32'(fractionModeSelect), 32'h0, "integer select");
    check(32'(loopMultiplier), 32'h03ff0000, "integer mult");
    $display("test mult done");
  endtask : test_mult

  task automatic test_source;
    for (int s = 0; s < 3; s++) begin
      bus_write(IDX_DIVIDER, 16'(s << 11));
      repeat (3) @(posedge clock);
      check(32'({referenceSourceReserved, referenceSourceSelect}), 32'(s), "source");
    end
    bus_write(IDX_DIVIDER, 16'h1800);
    repeat (3) @(posedge clock);
    check(32'({referenceSourceReserved, referenceSourceSelect}), 32'h6, "reserved");
    bus_read(IDX_STATUS);
    check(32'(rd[7:5]), 32'h6, "status source");
    $display("test source done");
  endtask : test_source

  task automatic test_dividers;
    bus_write(IDX_CONTROL, 16'h0005);
    check(32'(loopEnable), 32'h1, "loop enable");
    bus_read(IDX_CONTROL);
    check(rd, 32'h0005, "control back");
    for (int c = 0; c < 8; c++) begin
      bus_write(IDX_DIVIDER, 16'(c << 3));
      measure(1'b0);
      check(32'(per), 32'(2 << c), "output divider");
    end
    for (int c = 5; c < 8; c++) begin
      bus_write(IDX_DIVIDER, 16'(c << 6));
      measure(1'b1);
      check(32'(per), 32'(c + 1), "control rate");
    end
    bus_write(IDX_CONTROL, 16'h0000);
    $display("test dividers done");
  endtask : test_dividers

  task automatic test_unmapped;
    bus_write(8'h90, 16'h1234);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    bus_read(8'h90);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    check(rd, 32'h0, "unmapped data");
    bus_write(IDX_STATUS, 16'h00ff);
    check(32'(rsp), 32'(RESP_OKAY), "status write");
    $display("test unmapped done");
  endtask : test_unmapped

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h3;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    test_reset();
    test_ratio();
    test_mult();
    test_source();
    test_dividers();
    test_unmapped();
    print_verdict();
  end

  initial begin
    #400000;
    mismatches++;
    $display("[ERR] t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule : test_flr_ratio_config
